// ===== shared/pmc_pkg.sv
package pmc_pkg;
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_BUS = 8'h02;
    localparam logic [7:0] ADDR_POWER = 8'h03;
    localparam logic [7:0] ADDR_CURRENT = 8'h04;
    localparam logic [7:0] ADDR_CAL = 8'h05;
    localparam logic [7:0] ADDR_SHUNT_LIM = 8'h06;
    localparam logic [7:0] ADDR_BUS_LIM = 8'h07;
    localparam logic [7:0] ADDR_WARN = 8'h08;
    localparam logic [7:0] ADDR_AUX = 8'h09;
    localparam int BUS_CONVERSION_READY_FLAG_BIT = 1;
    localparam int BUS_OVF_BIT = 0;
    localparam int BUS_DATA_LSB = 2;
    localparam int WARN_SHUNT_OVER = 3;
    localparam int WARN_SHUNT_UNDER = 2;
    localparam int WARN_BUS_OVER = 1;
    localparam int WARN_BUS_UNDER = 0;
    localparam int AUX_FORCE_BIT = 8;
    localparam int AUX_IRQ_EN_BIT = 7;
    localparam int AUX_EXTCLK_BIT = 6;
    localparam int AUX_W = 9;
    localparam int WARN_W = 4;
    localparam int MATH_SHIFT = 12;
    localparam int MATH_RES = 4096;
    localparam int POWER_SCALE = 5000;
    localparam int SHUNT_LIM_SHIFT = 8;
    localparam int BUS_LIM_SHIFT = 6;
    localparam int SHUNT_FULL_RES = 15;
    localparam int SHUNT_MIN_RES = 12;
    localparam logic [3:0] SHUNT_SET_FULL = 4'h3;
    localparam logic [1:0] RANGE_16V = 2'h0;
    localparam logic [1:0] RANGE_32V = 2'h1;
    localparam logic [15:0] CAL_RESET = 16'h0000;
    localparam logic [15:0] LIM_RESET = 16'h0000;
    localparam logic [AUX_W-1:0] AUX_RESET = 9'h000;
    localparam logic [WARN_W-1:0] WARN_RESET = 4'h0;

    typedef struct packed {
        logic [15:0] shunt;
        logic [13:0] bus;
    } pmc_reading_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } pmc_req_t;
endpackage

// ===== design/pmc_math.sv
`timescale 1ns/100ps
module pmc_math
(
    input wire logic signed [15:0] shunt,
    input wire logic [13:0] bus,
    input wire logic [15:0] cal,
    input wire logic range_60v,
    output logic [15:0] current,
    output logic [15:0] power,
    output logic overflow
);
    import pmc_pkg::*;
    logic signed [32:0] prod;
    logic signed [32:0] cur_full;
    logic [32:0] mag;
    logic [47:0] pwr_prod;
    logic [47:0] pwr_full;
    logic cur_ovf;
    logic pwr_ovf;

    always_comb
    begin
        // Shunt times calibration, truncated by the math resolution
        prod = shunt * $signed({1'b0, cal});
        cur_full = prod >>> MATH_SHIFT;
        cur_ovf = (cur_full[32:15] != {18{cur_full[15]}});
        mag = cur_full[32] ? 33'(-cur_full) : 33'(cur_full);
        pwr_prod = 48'(mag) * 48'(bus);
        pwr_full = pwr_prod / 48'(POWER_SCALE);
        if (range_60v)
        begin
            pwr_full = pwr_full << 1;
        end
        pwr_ovf = (pwr_full[47:16] != 32'h0000_0000);
        current = cur_full[15:0];
        power = pwr_full[15:0];
        overflow = cur_ovf | pwr_ovf;
    end
endmodule

// ===== design/pmc_limits.sv
`timescale 1ns/100ps
module pmc_limits
(
    input wire logic signed [15:0] shunt,
    input wire logic [13:0] bus,
    input wire logic [15:0] shunt_lim,
    input wire logic [15:0] bus_lim,
    output logic [3:0] hits
);
    import pmc_pkg::*;
    logic signed [15:0] s_max;
    logic signed [15:0] s_min;
    logic [15:0] b_max;
    logic [15:0] b_min;

    always_comb
    begin
        // Sign-extend shunt limits, zero-extend bus limits, then scale
        s_max = $signed(16'($signed(shunt_lim[15:8]))) <<< SHUNT_LIM_SHIFT;
        s_min = $signed(16'($signed(shunt_lim[7:0]))) <<< SHUNT_LIM_SHIFT;
        b_max = 16'(bus_lim[15:8]) << BUS_LIM_SHIFT;
        b_min = 16'(bus_lim[7:0]) << BUS_LIM_SHIFT;
        hits = '0;
        hits[WARN_SHUNT_OVER] = shunt > s_max;
        hits[WARN_SHUNT_UNDER] = shunt < s_min;
        hits[WARN_BUS_OVER] = 16'(bus) > b_max;
        hits[WARN_BUS_UNDER] = 16'(bus) < b_min;
    end
endmodule

// ===== design/pmc_power_monitor_core.sv
// Functional notes
// - Bus reading in bits 15:2, 4mV each
// - Bus range selects 12, 13 or 14 bits
// - Ready flag low converting, high when done in triggered mode
// - Config write or power read clears ready
// - Overflow bit flags invalid current or power
// - Calibration read/write, bit 0 reads zero
// - Math scaling resolution is 4096
// - Shunt setting 3 or more gives 15 bits
// - Current is signed 16-bit result
// - Power is unsigned 16-bit result
// - Power scaled by 5000, doubled at 60V
// - Limits checked once per finished conversion
// - Limit violation sets warning, maybe interrupt
// - Shunt limits are signed byte pair
// - Bus limits are unsigned byte pair
// - Warning bits 3 to 0, rest zero
// - Aux holds force, enable, extclk, divider
// - Host writes one to clear warning
// - Bus limit count weighs 256mV
// - Enabled warning or force drives pin low unless extclk is set
// - External clock divided by twice divider+1
`timescale 1ns/100ps
module pmc_power_monitor_core
#(
    parameter int BUS_W = 14
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire pmc_pkg::pmc_req_t req,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire pmc_pkg::pmc_reading_t reading,
    input wire logic [1:0] bus_range_select,
    input wire logic [3:0] shunt_converter_setting,
    input wire logic triggered_mode,
    input wire logic pin_in,
    output logic [15:0] rdata,
    output logic rvalid,
    output logic pin_out,
    output logic pin_oe,
    output logic core_tick
);
    import pmc_pkg::*;

    initial
    begin
        if (BUS_W != 14)
        begin
            $error("BUS_W must be 14");
        end
    end

    logic rst_a_ff;
    logic rst_b_ff;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end
        else
        begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end
    assign rst_n = rst_b_ff;

    function automatic logic hit(input pmc_req_t r, input logic [7:0] a);
        hit = (r.addr == a);
    endfunction

    logic [13:0] bus_mask;
    logic [15:0] shunt_res;
    logic [15:0] cur_c;
    logic [15:0] pwr_c;
    logic ovf_c;
    logic [3:0] hits;
    logic pwr_read;
    logic cfg_write;

    logic [13:0] bus_ff, nxt_bus;
    logic [15:0] cur_ff, nxt_cur;
    logic [15:0] pwr_ff, nxt_pwr;
    logic conversion_ready_flag_ff, nxt_conversion_ready_flag;
    logic ovf_ff, nxt_ovf;
    logic [15:0] cal_ff, nxt_cal;
    logic [15:0] slim_ff, nxt_slim;
    logic [15:0] blim_ff, nxt_blim;
    logic [WARN_W-1:0] warn_ff, nxt_warn;
    logic [AUX_W-1:0] aux_ff, nxt_aux;
    logic [15:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic pin_oe_ff, nxt_pin_oe;
    logic pin_q_ff, nxt_pin_q;
    logic [6:0] div_cnt_ff, nxt_div_cnt;
    logic tick_ff, nxt_tick;

    always_comb
    begin
        bus_mask = 14'h3FFF;
        if (bus_range_select == RANGE_16V)
        begin
            bus_mask = 14'h0FFF;
        end
        else if (bus_range_select == RANGE_32V)
        begin
            bus_mask = 14'h1FFF;
        end
        shunt_res = reading.shunt;
        if (shunt_converter_setting < SHUNT_SET_FULL)
        begin
            shunt_res = reading.shunt & (16'hFFFF << (SHUNT_FULL_RES
                - SHUNT_MIN_RES - 32'(shunt_converter_setting)));
        end
    end

    pmc_math u_math
    (
        .shunt(shunt_res),
        .bus(reading.bus & bus_mask),
        .cal(cal_ff),
        .range_60v(bus_range_select[1]),
        .current(cur_c),
        .power(pwr_c),
        .overflow(ovf_c)
    );

    pmc_limits u_limits
    (
        .shunt(shunt_res),
        .bus(reading.bus & bus_mask),
        .shunt_lim(slim_ff),
        .bus_lim(blim_ff),
        .hits(hits)
    );

    assign pwr_read = req.rd && hit(req, ADDR_POWER);
    assign cfg_write = req.wr && hit(req, ADDR_CONFIG);

    always_comb
    begin
        nxt_bus = bus_ff;
        nxt_cur = cur_ff;
        nxt_pwr = pwr_ff;
        nxt_ovf = ovf_ff;
        nxt_conversion_ready_flag = conversion_ready_flag_ff;
        nxt_cal = cal_ff;
        nxt_slim = slim_ff;
        nxt_blim = blim_ff;
        nxt_warn = warn_ff;
        nxt_aux = aux_ff;
        nxt_rdata = rdata_ff;
        nxt_rvalid = req.rd;
        if (cfg_write || pwr_read || conv_start)
        begin
            nxt_conversion_ready_flag = 1'b0;
        end
        if (req.wr)
        begin
            if (hit(req, ADDR_CAL))
            begin
                nxt_cal = {req.wdata[15:1], 1'b0};
            end
            else if (hit(req, ADDR_SHUNT_LIM))
            begin
                nxt_slim = req.wdata;
            end
            else if (hit(req, ADDR_BUS_LIM))
            begin
                nxt_blim = req.wdata;
            end
            else if (hit(req, ADDR_WARN))
            begin
                nxt_warn = warn_ff & ~req.wdata[WARN_W-1:0];
            end
            else if (hit(req, ADDR_AUX))
            begin
                nxt_aux = req.wdata[AUX_W-1:0];
            end
        end
        if (conv_done)
        begin
            nxt_bus = reading.bus & bus_mask;
            nxt_cur = cur_c;
            nxt_pwr = pwr_c;
            nxt_ovf = ovf_c;
            nxt_warn = nxt_warn | hits;
            if (triggered_mode)
            begin
                nxt_conversion_ready_flag = 1'b1;
            end
        end
        if (req.rd)
        begin
            nxt_rdata = 16'h0000;
            if (hit(req, ADDR_BUS))
            begin
                nxt_rdata = {bus_ff, conversion_ready_flag_ff, ovf_ff};
            end
            else if (hit(req, ADDR_POWER))
            begin
                nxt_rdata = pwr_ff;
            end
            else if (hit(req, ADDR_CURRENT))
            begin
                nxt_rdata = cur_ff;
            end
            else if (hit(req, ADDR_CAL))
            begin
                nxt_rdata = cal_ff;
            end
            else if (hit(req, ADDR_SHUNT_LIM))
            begin
                nxt_rdata = slim_ff;
            end
            else if (hit(req, ADDR_BUS_LIM))
            begin
                nxt_rdata = blim_ff;
            end
            else if (hit(req, ADDR_WARN))
            begin
                nxt_rdata = 16'(warn_ff);
            end
            else if (hit(req, ADDR_AUX))
            begin
                nxt_rdata = 16'(aux_ff);
            end
        end
    end

    always_comb
    begin
        // Open-drain low on force, or on an enabled warning, unless extclk is set
        nxt_pin_oe = !aux_ff[AUX_EXTCLK_BIT] && (aux_ff[AUX_FORCE_BIT]
            || (aux_ff[AUX_IRQ_EN_BIT] && (warn_ff != '0)));
        nxt_pin_q = pin_in;
        nxt_div_cnt = div_cnt_ff;
        nxt_tick = 1'b0;
        if (aux_ff[AUX_EXTCLK_BIT] && pin_in && !pin_q_ff)
        begin
            // One tick per 2*(divider+1) rising pin edges
            if (div_cnt_ff >= {aux_ff[5:0], 1'b1})
            begin
                nxt_div_cnt = 7'h00;
                nxt_tick = 1'b1;
            end
            else
            begin
                nxt_div_cnt = div_cnt_ff + 7'h01;
            end
        end
        else if (!aux_ff[AUX_EXTCLK_BIT])
        begin
            nxt_div_cnt = 7'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_ff <= 14'h0000;
            cur_ff <= 16'h0000;
            pwr_ff <= 16'h0000;
            ovf_ff <= 1'b0;
            conversion_ready_flag_ff <= 1'b0;
            cal_ff <= CAL_RESET;
            slim_ff <= LIM_RESET;
            blim_ff <= LIM_RESET;
            warn_ff <= WARN_RESET;
            aux_ff <= AUX_RESET;
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
            pin_q_ff <= 1'b0;
            div_cnt_ff <= 7'h00;
            tick_ff <= 1'b0;
        end
        else
        begin
            bus_ff <= nxt_bus;
            cur_ff <= nxt_cur;
            pwr_ff <= nxt_pwr;
            ovf_ff <= nxt_ovf;
            conversion_ready_flag_ff <= nxt_conversion_ready_flag;
            cal_ff <= nxt_cal;
            slim_ff <= nxt_slim;
            blim_ff <= nxt_blim;
            warn_ff <= nxt_warn;
            aux_ff <= nxt_aux;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            pin_oe_ff <= nxt_pin_oe;
            pin_q_ff <= nxt_pin_q;
            div_cnt_ff <= nxt_div_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign rdata = rdata_ff;
    assign rvalid = rvalid_ff;
    assign pin_out = 1'b0;
    assign pin_oe = pin_oe_ff;
    assign core_tick = tick_ff;

    sequence s_done_trig;
        conv_done && triggered_mode;
    endsequence
    sequence s_pwr_read;
        pwr_read && !conv_done;
    endsequence
    sequence s_bus_read;
        req.rd && hit(req, ADDR_BUS);
    endsequence

    a_ready_sets: assert property (@(posedge clk) disable iff (!rst_n)
        s_done_trig |=> conversion_ready_flag_ff)
        else $error("ready flag not set after conversion");
    a_ready_clears: assert property (@(posedge clk) disable iff (!rst_n)
        s_pwr_read |=> !conversion_ready_flag_ff)
        else $error("ready flag not cleared by power read");
    a_cfg_clears: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_write && !conv_done |=> !conversion_ready_flag_ff)
        else $error("ready flag not cleared by config write");
    a_cal_bit0: assert property (@(posedge clk) disable iff (!rst_n)
        cal_ff[0] == 1'b0)
        else $error("calibration bit 0 not zero");
    a_warn_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        warn_ff[0] && !(req.wr && hit(req, ADDR_WARN)) |=> warn_ff[0])
        else $error("warning bit lost without clear");
    a_warn_set: assert property (@(posedge clk) disable iff (!rst_n)
        conv_done && hits[WARN_BUS_OVER] |=> warn_ff[WARN_BUS_OVER])
        else $error("bus over warning not set");
    a_no_check_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !conv_done && !req.wr |=> warn_ff == $past(warn_ff))
        else $error("warning changed without conversion");
    a_force_pin: assert property (@(posedge clk) disable iff (!rst_n)
        aux_ff[AUX_FORCE_BIT] && !aux_ff[AUX_EXTCLK_BIT] |=> pin_oe)
        else $error("force did not drive pin low");
    a_extclk_release: assert property (@(posedge clk) disable iff (!rst_n)
        aux_ff[AUX_EXTCLK_BIT] |=> !pin_oe)
        else $error("pin driven while external clock");
    a_bus_result: assert property (@(posedge clk) disable iff (!rst_n)
        s_bus_read |=> rdata[15:2] == $past(bus_ff))
        else $error("bus result read mismatch");
endmodule

// ===== bench/pmc_far_model.sv
`timescale 1ns/100ps
module pmc_far_model
(
    input wire logic clk,
    input wire logic clk_run,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    output pmc_pkg::pmc_req_t req,
    output logic conv_start,
    output logic conv_done,
    output pmc_pkg::pmc_reading_t reading,
    output logic ext_lvl
);
    import pmc_pkg::*;

    initial
    begin
        req = '0;
        conv_start = 1'b0;
        conv_done = 1'b0;
        reading = '0;
        ext_lvl = 1'b1;
    end

    // Clock source only while asked; pull-up level otherwise
    always @(negedge clk)
    begin
        if (clk_run)
            ext_lvl <= ~ext_lvl;
        else
            ext_lvl <= 1'b1;
    end

    task automatic host_write(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask

    task automatic host_read(input logic [7:0] a, output logic [15:0] d,
                             output logic v);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        // Answer stands for one cycle after the read edge
        d = rdata;
        v = rvalid;
        req = '0;
    endtask

    task automatic convert(input logic [15:0] s, input logic [13:0] b);
        @(negedge clk);
        conv_start = 1'b1;
        @(negedge clk);
        conv_start = 1'b0;
        conv_done = 1'b1;
        reading = '{shunt: s, bus: b};
        @(negedge clk);
        conv_done = 1'b0;
        // Released readings must not look valid
        reading = ~reading;
        @(negedge clk);
    endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import pmc_pkg::*;
    logic clk;
    logic resetn;
    logic clk_run;
    logic [1:0] range_sel;
    logic [3:0] shunt_set;
    logic trig;
    pmc_req_t req;
    pmc_reading_t reading;
    logic conv_start;
    logic conv_done;
    logic ext_lvl;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic core_tick;
    logic rvalid;
    logic [15:0] rdata;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int ticks = 0;

    // Open-drain wire: low while the core pulls it
    assign pin_in = pin_oe ? pin_out : ext_lvl;

    pmc_power_monitor_core dut (.clk(clk), .resetn(resetn), .req(req),
        .conv_start(conv_start), .conv_done(conv_done), .reading(reading),
        .bus_range_select(range_sel), .shunt_converter_setting(shunt_set),
        .triggered_mode(trig), .pin_in(pin_in), .rdata(rdata),
        .rvalid(rvalid), .pin_out(pin_out), .pin_oe(pin_oe),
        .core_tick(core_tick));

    pmc_far_model model (.clk(clk), .clk_run(clk_run), .rdata(rdata),
        .rvalid(rvalid), .req(req), .conv_start(conv_start),
        .conv_done(conv_done), .reading(reading), .ext_lvl(ext_lvl));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (core_tick === 1'b1)
            ticks++;
        if (cycles == 5000)
        begin
            fail_count++;
            test_done();
        end
    end

    task automatic test_done();
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        model.host_read(a, d, v);
        chk((v === 1'b1) ? d : ~exp, exp);
    endtask

    task automatic t_regs();
        model.host_write(ADDR_CURRENT, 16'h1234);
        rd_chk(ADDR_CURRENT, 16'h0000);
        rd_chk(8'h0A, 16'h0000);
        model.host_write(ADDR_CAL, 16'hABCD);
        rd_chk(ADDR_CAL, 16'hABCC);
    endtask

    task automatic t_math();
        model.host_write(ADDR_CAL, 16'h0800);
        model.convert(16'h1000, 14'h0FA0);
        rd_chk(ADDR_BUS, {14'h0FA0, 2'b10});
        rd_chk(ADDR_CURRENT, 16'h0800);
        rd_chk(ADDR_POWER, 16'h0666);
        rd_chk(ADDR_BUS, {14'h0FA0, 2'b00});
        range_sel = 2'h2;
        model.convert(16'h1000, 14'h0FA0);
        rd_chk(ADDR_POWER, 16'h0CCC);
        range_sel = 2'h1;
        model.convert(16'h1000, 14'h3FA0);
        rd_chk(ADDR_BUS, {14'h1FA0, 2'b10});
        rd_chk(ADDR_POWER, 16'h0CF4);
        range_sel = 2'h2;
        model.convert(16'h1000, 14'h0FA0);
        model.host_write(ADDR_CONFIG, 16'h0000);
        rd_chk(ADDR_BUS, {14'h0FA0, 2'b00});
        model.host_write(ADDR_CAL, 16'h1000);
        shunt_set = 4'h0;
        model.convert(16'h1007, 14'h0FA0);
        rd_chk(ADDR_CURRENT, 16'h1000);
        shunt_set = 4'h2;
        model.convert(16'h1007, 14'h0FA0);
        rd_chk(ADDR_CURRENT, 16'h1006);
        shunt_set = 4'h3;
        model.convert(16'h1007, 14'h0FA0);
        rd_chk(ADDR_CURRENT, 16'h1007);
    endtask

    task automatic t_ovf();
        model.host_write(ADDR_CAL, 16'hFFFE);
        model.convert(16'h7FFF, 14'h0FA0);
        rd_chk(ADDR_BUS, {14'h0FA0, 2'b11});
        trig = 1'b0;
        model.convert(16'h0000, 14'h0FA0);
        rd_chk(ADDR_BUS, {14'h0FA0, 2'b00});
        trig = 1'b1;
    endtask

    task automatic t_limits();
        model.host_write(ADDR_CAL, 16'h0000);
        model.host_write(ADDR_WARN, 16'h000F);
        model.host_write(ADDR_SHUNT_LIM, 16'h10F0);
        rd_chk(ADDR_SHUNT_LIM, 16'h10F0);
        model.host_write(ADDR_BUS_LIM, 16'h4010);
        rd_chk(ADDR_BUS_LIM, 16'h4010);
        model.host_write(ADDR_AUX, 16'h0080);
        rd_chk(ADDR_AUX, 16'h0080);
        model.convert(16'h1000, 14'h1000);
        rd_chk(ADDR_WARN, 16'h0000);
        chk({15'h0000, pin_oe}, 16'h0000);
        model.convert(16'h2000, 14'h0200);
        rd_chk(ADDR_WARN, 16'h0009);
        chk({15'h0000, pin_oe}, 16'h0001);
        model.host_write(ADDR_WARN, 16'h0008);
        rd_chk(ADDR_WARN, 16'h0001);
        model.host_write(ADDR_WARN, 16'hFFF1);
        rd_chk(ADDR_WARN, 16'h0000);
        chk({15'h0000, pin_oe}, 16'h0000);
        model.convert(16'hE000, 14'h1100);
        rd_chk(ADDR_WARN, 16'h0006);
        model.host_write(ADDR_WARN, 16'h0006);
        model.host_write(ADDR_AUX, 16'h0100);
        model.convert(16'h0000, 14'h0800);
        chk({15'h0000, pin_oe}, 16'h0001);
    endtask

    task automatic t_extclk();
        model.host_write(ADDR_AUX, 16'h0141);
        rd_chk(ADDR_AUX, 16'h0141);
        chk({15'h0000, pin_oe}, 16'h0000);
        ticks = 0;
        clk_run = 1'b1;
        repeat (32) @(negedge clk);
        clk_run = 1'b0;
        repeat (6) @(negedge clk);
        chk(ticks[15:0], 16'h0004);
    endtask

    initial
    begin
        resetn = 1'b0;
        clk_run = 1'b0;
        range_sel = 2'h0;
        shunt_set = 4'h3;
        trig = 1'b1;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_regs();
        t_math();
        t_ovf();
        t_limits();
        t_extclk();
        test_done();
    end
endmodule
